// [shared/lcd_seq_defines.svh]
// Timing constants and command codes shared by both ends of the reset link
//
// Summary of operation
// RL1 - Reject reset pulses under 5us; accept longer
// RL2 - Reload stored settings after every reset release
// RL3 - Host waits 5ms after release before commands
// RL4 - Host delays sleep-exit until 120ms after release
// RL5 - Awake reset runs blanking, at most 120ms
// RL6 - Sleeping reset stays blank; all end default
// RL7 - Glitches inside valid pulse are filtered too
// RL8 - Reset in deep standby lands in sleep
// RL9 - Host leaves 1ms between second, third select
// RL10 - Host finishes standby exit before pixel writes
// RL11 - Host restores display with display-on sequence
// RL12 - Host rewrites memory and settings after standby
// RL13 - Deep standby restarts regulator before initial state
// RL14 - Reset low time measured by cycle counter
// RL15 - Commands refused until settings reload completes
`ifndef LCD_SEQ_DEFINES_SVH
`define LCD_SEQ_DEFINES_SVH

// ******************************************************************
// Clock
// ******************************************************************
`define CLK_MHZ              50
`define CLK_KHZ              50000

// ******************************************************************
// Reset pin filter
// ******************************************************************
`define RESET_REJECT_US      5
`define RESET_REJECT_CYC     (`RESET_REJECT_US * `CLK_MHZ)
`define RESET_FULL_US        10
`define RESET_FULL_CYC       (`RESET_FULL_US * `CLK_MHZ)

// ******************************************************************
// Device sequencing times
// ******************************************************************
`define RESET_CANCEL_MS      5
`define RESET_CANCEL_CYC     (`RESET_CANCEL_MS * `CLK_KHZ)
`define NV_RELOAD_US         50
`define NV_RELOAD_CYC        (`NV_RELOAD_US * `CLK_MHZ)
`define BLANK_MAX_MS         120
`define BLANK_MAX_CYC        (`BLANK_MAX_MS * `CLK_KHZ)
`define REGULATOR_US         20
`define REGULATOR_CYC        (`REGULATOR_US * `CLK_MHZ)

// ******************************************************************
// Host sequencing times
// ******************************************************************
`define SLEEP_EXIT_MS        120
`define SLEEP_EXIT_CYC       (`SLEEP_EXIT_MS * `CLK_KHZ)
`define RESET_PULSE_US       20
`define RESET_PULSE_CYC      (`RESET_PULSE_US * `CLK_MHZ)
`define DSB_GAP_MS           1
`define DSB_GAP_CYC          (`DSB_GAP_MS * `CLK_KHZ)
`define DSB_SHORT_GAP_CYC    8
`define CS_LOW_CYC           4

// ******************************************************************
// Command codes
// ******************************************************************
`define CMD_SLEEP_IN         8'h10
`define CMD_SLEEP_OUT        8'h11
`define CMD_DISPLAY_OFF      8'h28
`define CMD_DISPLAY_ON       8'h29
`define CMD_MEM_WRITE        8'h2c
`define CMD_DSTB_ENTER       8'hb7
`define DSB_CS_PULSES        2'h3

`endif

// [shared/lcd_seq_pkg.sv]
// State types for both ends of the reset link
package lcd_seq_pkg;

    typedef enum logic [5:0] {
        S_RUN    = 6'b000001,
        S_BLANK  = 6'b000010,
        S_HOLD   = 6'b000100,
        S_REGUL  = 6'b001000,
        S_RELOAD = 6'b010000,
        S_DEEP   = 6'b100000
    } dev_state_t;

    typedef enum logic [4:0] {
        H_RST_LOW = 5'b00001,
        H_WAIT    = 5'b00010,
        H_READY   = 5'b00100,
        H_DSB_LOW = 5'b01000,
        H_DSB_GAP = 5'b10000
    } host_state_t;

endpackage

// [shared/lcd_seq_if.sv]
// Link between host controller and display driver reset sequencer
interface lcd_seq_if;
    logic       hw_reset_pin_n;
    logic       chip_select_pin_n;
    logic       cmd_strobe;
    logic [7:0] cmd_code;
    logic       cmd_ack;
    logic       cmd_nak;

    modport device (
        input  hw_reset_pin_n,
        input  chip_select_pin_n,
        input  cmd_strobe,
        input  cmd_code,
        output cmd_ack,
        output cmd_nak
    );

    modport host (
        output hw_reset_pin_n,
        output chip_select_pin_n,
        output cmd_strobe,
        output cmd_code,
        input  cmd_ack,
        input  cmd_nak
    );
endinterface

// [src/lcd_seq_device.sv]
// Display driver end: reset pin filter, blanking, reload and deep standby exit
`include "lcd_seq_defines.svh"

module lcd_seq_device #(
    parameter logic [31:0] BLANK_CYC = `BLANK_MAX_CYC
) (
    input  wire logic           clk,
    input  wire logic           reset,
    input  wire logic           ce,
    lcd_seq_if.device           link,
    input  wire logic [7:0]     nv_id,
    input  wire logic [6:0]     nv_common_electrode_level,
    output      logic [7:0]     id_value,
    output      logic [6:0]     common_electrode_level,
    output      logic           sleep_mode,
    output      logic           deep_standby,
    output      logic           display_blank,
    output      logic           blanking,
    output      logic           reloading,
    output      logic           reset_long,
    output      logic           cmd_out_valid,
    output      logic [7:0]     cmd_out_code
);

    // ******************************************************************
    // Pin synchronisers
    // ******************************************************************
    logic [2:0]  rst_sync_reg;
    logic [2:0]  cs_sync_reg;
    logic        rst_level_reg;
    logic        cs_level_reg;
    logic        cs_prev_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            rst_sync_reg  <= 3'h7;
            cs_sync_reg   <= 3'h7;
            rst_level_reg <= 1'b1;
            cs_level_reg  <= 1'b1;
            cs_prev_reg   <= 1'b1;
        end else if (ce) begin
            rst_sync_reg <= {rst_sync_reg[1:0], link.hw_reset_pin_n};
            cs_sync_reg  <= {cs_sync_reg[1:0], link.chip_select_pin_n};
            cs_prev_reg  <= cs_level_reg;
            if (rst_sync_reg[1] == rst_sync_reg[2]) begin
                rst_level_reg <= rst_sync_reg[2];
            end
            if (cs_sync_reg[1] == cs_sync_reg[2]) begin
                cs_level_reg <= cs_sync_reg[2];
            end
        end
    end

    wire pin_low = ~rst_level_reg;
    wire cs_fall = cs_prev_reg & ~cs_level_reg;

    // ******************************************************************
    // Reset pulse measurement
    // ******************************************************************
    localparam logic [9:0] REJECT_LAST = 10'(`RESET_REJECT_CYC - 1);
    localparam logic [9:0] FULL_LAST   = 10'(`RESET_FULL_CYC - 1);

    logic [9:0]  low_cnt_reg;
    logic [9:0]  high_cnt_reg;
    logic        pulse_valid_reg;
    logic        reset_long_reg;

    wire low_sat     = (low_cnt_reg == FULL_LAST);
    wire reset_start = ~pulse_valid_reg & pin_low & (low_cnt_reg == REJECT_LAST); // RL1 RL14
    wire release_ok  = pulse_valid_reg & ~pin_low & (high_cnt_reg == REJECT_LAST); // RL7

    always_ff @(posedge clk) begin
        if (reset) begin
            low_cnt_reg     <= 10'h000;
            high_cnt_reg    <= 10'h000;
            pulse_valid_reg <= 1'b0;
            reset_long_reg  <= 1'b0;
        end else if (ce) begin
            if (pin_low) begin
                high_cnt_reg <= 10'h000;
                low_cnt_reg  <= low_sat ? low_cnt_reg : low_cnt_reg + 10'h001; // RL14
            end else if (!pulse_valid_reg || release_ok) begin
                low_cnt_reg  <= 10'h000; // RL1
                high_cnt_reg <= 10'h000;
            end else begin
                high_cnt_reg <= high_cnt_reg + 10'h001; // RL7
            end
            if (reset_start) begin
                pulse_valid_reg <= 1'b1;
            end else if (release_ok) begin
                pulse_valid_reg <= 1'b0;
            end
            if (release_ok) begin
                reset_long_reg <= 1'b0;
            end else if (pulse_valid_reg && low_sat) begin
                reset_long_reg <= 1'b1; // RL1
            end
        end
    end

    // ******************************************************************
    // Sequencer
    // ******************************************************************
    lcd_seq_pkg::dev_state_t state_reg;
    logic [31:0] tmr_reg;
    logic        from_deep_reg;
    logic        sleep_reg;
    logic        disp_on_reg;
    logic [1:0]  cs_cnt_reg;
    logic [7:0]  id_reg;
    logic [6:0]  level_reg;
    logic        ack_reg;
    logic        nak_reg;
    logic        out_valid_reg;
    logic [7:0]  out_code_reg;

    wire in_run    = (state_reg == lcd_seq_pkg::S_RUN);
    wire cmd_take  = link.cmd_strobe & in_run; // RL15
    wire is_dstb   = (link.cmd_code == `CMD_DSTB_ENTER);
    wire cmd_bad   = cmd_take & is_dstb & ~sleep_reg;
    wire blank_end = (tmr_reg >= BLANK_CYC - 32'h1);
    wire regul_end = (tmr_reg == 32'(`REGULATOR_CYC - 1));
    wire load_end  = (tmr_reg == 32'(`NV_RELOAD_CYC - 1));

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg     <= lcd_seq_pkg::S_RUN;
            tmr_reg       <= 32'h0;
            from_deep_reg <= 1'b0;
            sleep_reg     <= 1'b1;
            disp_on_reg   <= 1'b0;
            cs_cnt_reg    <= 2'h0;
            id_reg        <= 8'h00;
            level_reg     <= 7'h00;
            ack_reg       <= 1'b0;
            nak_reg       <= 1'b0;
            out_valid_reg <= 1'b0;
            out_code_reg  <= 8'h00;
        end else if (ce) begin
            ack_reg       <= cmd_take & ~cmd_bad;
            nak_reg       <= (link.cmd_strobe & ~in_run) | cmd_bad; // RL15
            out_valid_reg <= cmd_take & ~cmd_bad;
            if (cmd_take) begin
                out_code_reg <= link.cmd_code;
            end
            tmr_reg <= tmr_reg + 32'h1;
            case (state_reg)
                lcd_seq_pkg::S_RUN: begin
                    if (reset_start) begin
                        tmr_reg <= 32'h0;
                        // Sleeping panel is already dark, no blanking pass
                        state_reg <= sleep_reg ? lcd_seq_pkg::S_HOLD
                                               : lcd_seq_pkg::S_BLANK; // RL5 RL6
                    end else if (cmd_take && !cmd_bad) begin
                        case (link.cmd_code)
                            `CMD_SLEEP_IN:    sleep_reg   <= 1'b1;
                            `CMD_SLEEP_OUT:   sleep_reg   <= 1'b0;
                            `CMD_DISPLAY_ON:  disp_on_reg <= 1'b1;
                            `CMD_DISPLAY_OFF: disp_on_reg <= 1'b0;
                            `CMD_DSTB_ENTER: begin
                                state_reg  <= lcd_seq_pkg::S_DEEP;
                                cs_cnt_reg <= 2'h0;
                            end
                            default: ;
                        endcase
                    end
                end
                lcd_seq_pkg::S_BLANK: begin
                    if (blank_end) begin
                        disp_on_reg <= 1'b0; // RL5
                        state_reg   <= lcd_seq_pkg::S_HOLD;
                    end
                end
                lcd_seq_pkg::S_HOLD: begin
                    disp_on_reg <= 1'b0; // RL6
                    sleep_reg   <= 1'b1;
                    tmr_reg     <= 32'h0;
                    if (!pulse_valid_reg) begin
                        state_reg <= from_deep_reg ? lcd_seq_pkg::S_REGUL
                                                   : lcd_seq_pkg::S_RELOAD; // RL13
                    end
                end
                lcd_seq_pkg::S_REGUL: begin
                    if (reset_start) begin
                        state_reg <= lcd_seq_pkg::S_HOLD;
                    end else if (regul_end) begin
                        tmr_reg   <= 32'h0;
                        state_reg <= lcd_seq_pkg::S_RELOAD; // RL13
                    end
                end
                lcd_seq_pkg::S_RELOAD: begin
                    if (reset_start) begin
                        state_reg <= lcd_seq_pkg::S_HOLD;
                    end else if (load_end) begin
                        id_reg        <= nv_id; // RL2
                        level_reg     <= nv_common_electrode_level;
                        from_deep_reg <= 1'b0;
                        state_reg     <= lcd_seq_pkg::S_RUN; // RL6 RL8
                    end
                end
                lcd_seq_pkg::S_DEEP: begin
                    // Settings are lost here, so every exit goes through reload
                    from_deep_reg <= 1'b1;
                    tmr_reg       <= 32'h0;
                    if (reset_start) begin
                        state_reg <= lcd_seq_pkg::S_HOLD; // RL8
                    end else if (cs_fall) begin
                        cs_cnt_reg <= cs_cnt_reg + 2'h1;
                        if (cs_cnt_reg == `DSB_CS_PULSES - 2'h1) begin
                            state_reg <= lcd_seq_pkg::S_REGUL; // RL13
                        end
                    end
                end
                default: state_reg <= lcd_seq_pkg::S_HOLD;
            endcase
            if (reset_start && state_reg != lcd_seq_pkg::S_RUN) begin
                tmr_reg <= (state_reg == lcd_seq_pkg::S_BLANK) ? tmr_reg + 32'h1 : 32'h0;
            end
        end
    end

    assign link.cmd_ack           = ack_reg;
    assign link.cmd_nak           = nak_reg;
    assign id_value               = id_reg;
    assign common_electrode_level = level_reg;
    assign sleep_mode             = sleep_reg;
    assign deep_standby           = (state_reg == lcd_seq_pkg::S_DEEP);
    assign display_blank          = ~in_run | sleep_reg | ~disp_on_reg; // RL6
    assign blanking               = (state_reg == lcd_seq_pkg::S_BLANK);
    assign reloading              = (state_reg == lcd_seq_pkg::S_RELOAD);
    assign reset_long             = reset_long_reg;
    assign cmd_out_valid          = out_valid_reg;
    assign cmd_out_code           = out_code_reg;

endmodule

// [src/lcd_seq_host.sv]
// Host end: reset pulse, command wait times and deep standby exit sequence
`include "lcd_seq_defines.svh"

module lcd_seq_host #(
    parameter logic [31:0] CMD_WAIT_CYC   = `RESET_CANCEL_CYC,
    parameter logic [31:0] SLEEP_EXIT_CYC = `SLEEP_EXIT_CYC,
    parameter logic [31:0] DSB_GAP_CYC    = `DSB_GAP_CYC
) (
    input  wire logic           clk,
    input  wire logic           reset,
    input  wire logic           ce,
    lcd_seq_if.host             link,
    input  wire logic           req_reset,
    input  wire logic           req_deep_exit,
    input  wire logic           req_valid,
    input  wire logic [7:0]     req_code,
    output      logic           req_ready,
    output      logic           sleep_exit_allowed,
    output      logic           restore_pending,
    output      logic           cmd_done,
    output      logic           cmd_refused
);

    lcd_seq_pkg::host_state_t state_reg;
    logic [31:0] tmr_reg;
    logic [31:0] since_rel_reg;
    logic [1:0]  pulse_cnt_reg;
    logic        rst_n_reg;
    logic        cs_n_reg;
    logic        strobe_reg;
    logic [7:0]  code_reg;
    logic        restore_reg;
    logic        done_reg;
    logic        refused_reg;

    // ******************************************************************
    // Request gating
    // ******************************************************************
    wire ready_st   = (state_reg == lcd_seq_pkg::H_READY);
    wire sleep_ok   = (since_rel_reg == SLEEP_EXIT_CYC); // RL4
    wire code_ok    = (req_code != `CMD_SLEEP_OUT) | sleep_ok; // RL4
    wire take       = req_valid & ready_st & code_ok & ~req_reset & ~req_deep_exit; // RL3 RL10
    wire [31:0] gap_last = (pulse_cnt_reg == 2'h2) ? DSB_GAP_CYC - 32'h1 // RL9
                                                   : 32'(`DSB_SHORT_GAP_CYC - 1);

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg     <= lcd_seq_pkg::H_RST_LOW;
            tmr_reg       <= 32'h0;
            since_rel_reg <= 32'h0;
            pulse_cnt_reg <= 2'h0;
            rst_n_reg     <= 1'b0;
            cs_n_reg      <= 1'b1;
            strobe_reg    <= 1'b0;
            code_reg      <= 8'h00;
            restore_reg   <= 1'b0;
            done_reg      <= 1'b0;
            refused_reg   <= 1'b0;
        end else if (ce) begin
            strobe_reg  <= take;
            done_reg    <= link.cmd_ack;
            refused_reg <= link.cmd_nak;
            if (take) begin
                code_reg <= req_code;
            end
            if (take && req_code == `CMD_DISPLAY_ON) begin
                restore_reg <= 1'b0; // RL11 RL12
            end
            if (rst_n_reg && !sleep_ok) begin
                since_rel_reg <= since_rel_reg + 32'h1; // RL4
            end
            tmr_reg <= tmr_reg + 32'h1;
            case (state_reg)
                lcd_seq_pkg::H_RST_LOW: begin
                    rst_n_reg     <= 1'b0;
                    since_rel_reg <= 32'h0;
                    // Pulse kept well above the full-reset width
                    if (tmr_reg == 32'(`RESET_PULSE_CYC - 1)) begin
                        rst_n_reg <= 1'b1;
                        tmr_reg   <= 32'h0;
                        state_reg <= lcd_seq_pkg::H_WAIT;
                    end
                end
                lcd_seq_pkg::H_WAIT: begin
                    if (tmr_reg == CMD_WAIT_CYC - 32'h1) begin
                        state_reg <= lcd_seq_pkg::H_READY; // RL3
                    end
                end
                lcd_seq_pkg::H_READY: begin
                    tmr_reg <= 32'h0;
                    if (req_reset) begin
                        state_reg <= lcd_seq_pkg::H_RST_LOW;
                    end else if (req_deep_exit) begin
                        pulse_cnt_reg <= 2'h0;
                        cs_n_reg      <= 1'b0;
                        state_reg     <= lcd_seq_pkg::H_DSB_LOW;
                    end
                end
                lcd_seq_pkg::H_DSB_LOW: begin
                    if (tmr_reg == 32'(`CS_LOW_CYC - 1)) begin
                        cs_n_reg      <= 1'b1;
                        tmr_reg       <= 32'h0;
                        pulse_cnt_reg <= pulse_cnt_reg + 2'h1;
                        state_reg     <= lcd_seq_pkg::H_DSB_GAP;
                    end
                end
                lcd_seq_pkg::H_DSB_GAP: begin
                    if (pulse_cnt_reg == `DSB_CS_PULSES) begin
                        restore_reg <= 1'b1; // RL12
                        tmr_reg     <= 32'h0;
                        state_reg   <= lcd_seq_pkg::H_WAIT; // RL10
                    end else if (tmr_reg == gap_last) begin
                        cs_n_reg  <= 1'b0;
                        tmr_reg   <= 32'h0;
                        state_reg <= lcd_seq_pkg::H_DSB_LOW;
                    end
                end
                default: state_reg <= lcd_seq_pkg::H_RST_LOW;
            endcase
        end
    end

    assign link.hw_reset_pin_n    = rst_n_reg;
    assign link.chip_select_pin_n = cs_n_reg;
    assign link.cmd_strobe        = strobe_reg;
    assign link.cmd_code          = code_reg;
    assign req_ready              = ready_st & code_ok & ~req_reset & ~req_deep_exit;
    assign sleep_exit_allowed     = sleep_ok;
    assign restore_pending        = restore_reg;
    assign cmd_done               = done_reg;
    assign cmd_refused            = refused_reg;

endmodule

// [sim/lcd_seq_sva.sv]
// Assertions on the link between host and display driver ends
`include "lcd_seq_defines.svh"

module lcd_seq_sva #(
    parameter int CMD_WAIT   = 3000,
    parameter int SLEEP_EXIT = 6000,
    parameter int DSB_GAP    = 100
) (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       hw_reset_pin_n,
    input wire logic       chip_select_pin_n,
    input wire logic       cmd_strobe,
    input wire logic [7:0] cmd_code,
    input wire logic       cmd_ack,
    input wire logic       cmd_nak
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Helper counters
    // ********
    logic [31:0] low_reg;
    logic [31:0] rel_reg;
    logic [31:0] hi_reg;
    logic [1:0]  falls_reg;
    logic        cs_q_reg;
    wire         cs_fall = cs_q_reg & ~chip_select_pin_n;
    // Falls wrap at three so a repeated exit sequence is judged afresh
    wire  [1:0]  falls_next = (falls_reg == 2'h2) ? 2'h0 : falls_reg + 2'h1;
    always_ff @(posedge clk) begin
        if (reset) begin
            falls_reg <= 2'h0;
            cs_q_reg  <= 1'b1;
            low_reg   <= 32'h0;
            rel_reg   <= 32'h0;
            hi_reg    <= 32'h0;
        end else begin
            falls_reg <= cs_fall ? falls_next : falls_reg;
            cs_q_reg  <= chip_select_pin_n;
            low_reg   <= hw_reset_pin_n ? 32'h0 : low_reg + 32'h1;
            rel_reg   <= hw_reset_pin_n ? rel_reg + 32'h1 : 32'h0;
            hi_reg    <= chip_select_pin_n ? hi_reg + 32'h1 : 32'h0;
        end
    end
    // ********
    // Properties
    // ********
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    chk_answer_next: assert property (cmd_strobe |=> cmd_ack ^ cmd_nak)
        else $error("command not answered next cycle");
    chk_no_stray: assert property ((cmd_ack | cmd_nak) |-> $past(cmd_strobe))
        else $error("answer without command");
    chk_pulse_len: assert property ($rose(hw_reset_pin_n) |-> low_reg >= `RESET_FULL_CYC)
        else $error("reset pulse shorter than 10us");
    chk_idle_reset: assert property (!hw_reset_pin_n |-> !cmd_strobe && chip_select_pin_n)
        else $error("traffic while reset pin low");
    chk_cmd_wait: assert property (cmd_strobe |-> rel_reg >= CMD_WAIT)
        else $error("command too soon after release");
    chk_sleep_exit: assert property (cmd_strobe && cmd_code == `CMD_SLEEP_OUT |-> rel_reg >= SLEEP_EXIT)
        else $error("sleep exit too soon after release");
    chk_dsb_gap: assert property (cs_fall && falls_reg == 2'h2 |-> hi_reg >= DSB_GAP)
        else $error("gap before third select too short");
    chk_cs_width: assert property ($fell(chip_select_pin_n) |-> !chip_select_pin_n[*4] ##1 chip_select_pin_n)
        else $error("select pulse width wrong");
    chk_exit_first: assert property (cmd_strobe |-> falls_reg == 2'h0 && hi_reg >= CMD_WAIT)
        else $error("command inside standby exit");
endmodule

// [sim/tb.sv]
// Bench joining host and device ends of the reset link
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BLANK = 200;
    localparam int CMD_WAIT = 4000;
    localparam int SLP_EXIT = 6000;
    localparam int GAP = 100;
    logic       clk, reset, req_reset, req_deep_exit, req_valid, req_ready;
    logic       sleep_exit_allowed, restore_pending, cmd_done, cmd_refused, out_valid;
    logic       sleep_mode, deep_standby, display_blank, blanking, reloading, reset_long;
    logic [7:0] req_code, nv_id, id_value, out_code;
    logic [6:0] nv_lvl, common_electrode_level;
    int         error_cnt = 0, checks = 0, cyc = 0, rel_at = 0, blank_cnt = 0;
    lcd_seq_if link ();
    lcd_seq_device #(.BLANK_CYC(BLANK)) i_lcd_seq_device (.clk(clk), .reset(reset),
        .ce(1'b1), .link(link), .nv_id(nv_id), .nv_common_electrode_level(nv_lvl),
        .id_value(id_value), .common_electrode_level(common_electrode_level),
        .sleep_mode(sleep_mode), .deep_standby(deep_standby), .display_blank(display_blank),
        .blanking(blanking), .reloading(reloading), .reset_long(reset_long),
        .cmd_out_valid(out_valid), .cmd_out_code(out_code));
    lcd_seq_host #(.CMD_WAIT_CYC(CMD_WAIT), .SLEEP_EXIT_CYC(SLP_EXIT), .DSB_GAP_CYC(GAP))
        i_lcd_seq_host (.clk(clk), .reset(reset), .ce(1'b1), .link(link),
        .req_reset(req_reset), .req_deep_exit(req_deep_exit), .req_valid(req_valid),
        .req_code(req_code), .req_ready(req_ready), .sleep_exit_allowed(sleep_exit_allowed),
        .restore_pending(restore_pending), .cmd_done(cmd_done), .cmd_refused(cmd_refused));
    lcd_seq_sva #(.CMD_WAIT(CMD_WAIT), .SLEEP_EXIT(SLP_EXIT), .DSB_GAP(GAP)) i_lcd_seq_sva (
        .clk(clk), .reset(reset), .hw_reset_pin_n(link.hw_reset_pin_n),
        .chip_select_pin_n(link.chip_select_pin_n), .cmd_strobe(link.cmd_strobe),
        .cmd_code(link.cmd_code), .cmd_ack(link.cmd_ack), .cmd_nak(link.cmd_nak));
    // ********
    // Tasks
    // ********
    task automatic end_sim();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 12000) begin
            @(negedge clk);
            n++;
        end
        chk("req_ready", 1, req_ready);
    endtask
    // Request held until taken, then outcome seen in its single cycle
    task automatic cmd(input logic [7:0] code, input logic ok);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req_code  <= code;
        n = 0;
        do begin @(negedge clk); n++; end while (req_ready !== 1'b1 && n < 10000);
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        do begin @(negedge clk); n++; end while (cmd_done !== 1'b1 && cmd_refused !== 1'b1 && n < 8);
        chk("cmd_done", ok, cmd_done);
        chk("cmd_refused", !ok, cmd_refused);
    endtask
    task automatic pulse_req(input logic deep);
        @(posedge clk);
        req_deep_exit <= deep;
        req_reset     <= !deep;
        @(posedge clk);
        req_deep_exit <= 1'b0;
        req_reset     <= 1'b0;
        @(negedge clk);
        blank_cnt = 0;
    endtask
    // ********
    // Clock, monitors, sequence
    // ********
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (blanking === 1'b1) blank_cnt++;
        if (link.cmd_ack === 1'b1) chk("cmd_out_valid", 1, out_valid);
        if (link.hw_reset_pin_n !== 1'b1) rel_at = cyc;
        if (cyc == 60000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        reset = 1'b1;
        {req_reset, req_deep_exit, req_valid} = 3'h0;
        req_code = 8'h00;
        nv_id = 8'h5a;
        nv_lvl = 7'h2b;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        wait_ready();
        chk("sleep_exit_allowed", 0, sleep_exit_allowed);
        chk("reloading", 0, reloading);
        chk("reset_long", 0, reset_long);
        chk("id_value", 8'h5a, id_value);
        chk("level", 7'h2b, common_electrode_level);
        chk("sleep_mode", 1, sleep_mode);
        chk("display_blank", 1, display_blank);
        chk("blank_cnt", 0, blank_cnt);
        $display("test power_up done");
        cmd(8'h11, 1);
        chk("exit_gap", 1, cyc - rel_at >= SLP_EXIT);
        cmd(8'h29, 1);
        chk("display_blank", 0, display_blank);
        cmd(8'hb7, 0);
        cmd(8'h2c, 1);
        chk("cmd_out_code", 8'h2c, out_code);
        $display("test commands done");
        nv_id = 8'ha5;
        pulse_req(0);
        repeat (600) @(negedge clk);
        chk("reset_long", 1, reset_long);
        wait_ready();
        chk("blank_len", 1, blank_cnt >= 1 && blank_cnt <= BLANK + 1);
        chk("id_value", 8'ha5, id_value);
        chk("sleep_mode", 1, sleep_mode);
        chk("display_blank", 1, display_blank);
        $display("test awake_reset done");
        cmd(8'hb7, 1);
        chk("deep_standby", 1, deep_standby);
        cmd(8'h29, 0);
        nv_lvl = 7'h54;
        pulse_req(1);
        wait_ready();
        chk("deep_standby", 0, deep_standby);
        chk("level", 7'h54, common_electrode_level);
        chk("restore_pending", 1, restore_pending);
        cmd(8'h29, 1);
        chk("restore_pending", 0, restore_pending);
        $display("test deep_exit done");
        cmd(8'hb7, 1);
        pulse_req(0);
        wait_ready();
        chk("deep_standby", 0, deep_standby);
        chk("sleep_mode", 1, sleep_mode);
        chk("blank_cnt", 0, blank_cnt);
        $display("test deep_reset done");
        end_sim();
    end
endmodule
